// File: hdl/cmp_ctrl_pkg.sv
package cmp_ctrl_pkg;

    // register byte addresses on the apb bus
    localparam logic [11:0] CTRL_OFFSET  = 12'h0F8;
    localparam logic [11:0] MUX_OFFSET   = 12'h0FC;
    localparam logic [11:0] MODE_OFFSET  = 12'h100;
    localparam logic [11:0] RESET_OFFSET = 12'h104;

    // control register field positions
    localparam int ENABLE_POS  = 7;
    localparam int STATE_POS   = 6;
    localparam int RISE_POS    = 5;
    localparam int FALL_POS    = 4;
    localparam int POS_HYS_LSB = 2;
    localparam int NEG_HYS_LSB = 0;

    // input mux register field positions
    localparam int POS_SEL_LSB = 0;
    localparam int NEG_SEL_LSB = 4;

    // reset values
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [3:0] MUX_RESET   = 4'h0;
    localparam logic [1:0] MODE_RESET  = 2'h0;
    localparam logic       RSTEN_RESET = 1'b0;

    // hysteresis encodings
    localparam logic [1:0] HYS_OFF   = 2'b00;
    localparam logic [1:0] HYS_5MV   = 2'b01;
    localparam logic [1:0] HYS_10MV  = 2'b10;
    localparam logic [1:0] HYS_20MV  = 2'b11;

    localparam int SYNC_STAGES = 2;

endpackage : cmp_ctrl_pkg

// File: hdl/cmp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module cmp_sync #(
    parameter int STAGES = 2
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // data
    input  wire logic asyncIn,
    output var  logic syncOut
);

    logic [STAGES-1:0] chain_r;

    // elaboration-time refusal: one stage would let metastability through
    if (STAGES < 2) begin : g_bad_stages
        $error("cmp_sync needs at least two stages");
    end

    // only the last stage is read outside this chain
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            chain_r <= '0;
        end else begin
            chain_r <= {chain_r[STAGES-2:0], asyncIn};
        end
    end

    assign syncOut = chain_r[STAGES-1];

endmodule : cmp_sync

`default_nettype wire

// File: hdl/comparator_control_logic.sv
// Behaviour
// - drive a clocked latched output and a raw unclocked output.
// - raw output is combinational, valid without any clock.
// - comparator output can be selected as a system reset source.
// - two-bit positive and negative input selects from input mux register.
// - result polled, raises edge events and drives pins; events and latched pin move together, a clock after the state bit.
// - both pin outputs forced low while the comparator is disabled, the latched one from the next clock.
// - two-bit response time select passed to the analog comparator.
// - low four control bits hold independent hysteresis fields.
// - edge events on both rising and falling output transitions.
// - falling edge sets falling flag, rising edge sets rising flag.
// - flags stay set until software writes zero.
// - live output state readable through a read-only bit.
// - writing enable bit one enables, zero disables the comparator.
// - control register at 0xF8 with documented layout, resets to zero.
// - hysteresis codes 00 off, 01 5mV, 10 10mV, 11 20mV.
// - state is one when positive input exceeds negative input.
`timescale 1ns/1ps
`default_nettype none

module comparator_control_logic
    import cmp_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog comparator core
    input  wire logic        cmpRawIn,
    output logic             cmpEnable,
    output logic [1:0]       pos_input_select,
    output logic [1:0]       neg_input_select,
    output logic [1:0]       response_time_select,
    output logic [1:0]       pos_hysteresis_sel,
    output logic [1:0]       neg_hysteresis_sel,
    // port pins and system
    output logic             cmp_latched_out,
    output logic             cmp_raw_out,
    output logic             risingEvent,
    output logic             fallingEvent,
    output logic             cmpResetReq
);

    logic       enable_r;
    logic       riseFlag_r;
    logic       fallFlag_r;
    logic [1:0] posHys_r;
    logic [1:0] negHys_r;
    logic [1:0] posSel_r;
    logic [1:0] negSel_r;
    logic [1:0] respTime_r;
    logic       resetEn_r;
    logic       syncOut;
    logic       prevOut_r;
    logic       latched_r;
    logic       riseEv_r;
    logic       fallEv_r;
    logic       resetReq_r;
    logic [31:0] rdata_r;
    logic       ready_r;
    logic       err_r;
    logic [7:0] ctrlView;
    logic       setup;
    logic       wrCtrl;
    logic       wrMux;
    logic       wrMode;
    logic       wrRst;
    logic       mapped;
    logic       riseEdge;
    logic       fallEdge;

    cmp_sync #(
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn (cmpRawIn),
        .syncOut (syncOut)
    );

    // zero-wait slave: answer one cycle after the setup cycle
    assign setup  = psel && !penable;
    assign mapped = (paddr == CTRL_OFFSET) || (paddr == MUX_OFFSET)
                 || (paddr == MODE_OFFSET) || (paddr == RESET_OFFSET);
    assign wrCtrl = psel && penable && pready && pwrite && pstrb[0]
                 && (paddr == CTRL_OFFSET);
    assign wrMux  = psel && penable && pready && pwrite && pstrb[0]
                 && (paddr == MUX_OFFSET);
    assign wrMode = psel && penable && pready && pwrite && pstrb[0]
                 && (paddr == MODE_OFFSET);
    assign wrRst  = psel && penable && pready && pwrite && pstrb[0]
                 && (paddr == RESET_OFFSET);

    assign riseEdge = enable_r && syncOut && !prevOut_r;
    assign fallEdge = enable_r && !syncOut && prevOut_r;

    assign ctrlView = {enable_r, syncOut, riseFlag_r, fallFlag_r,
                       posHys_r, negHys_r};

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ready_r <= 1'b0;
            err_r   <= 1'b0;
        end else begin
            ready_r <= setup;
            err_r   <= setup && !mapped;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else if (setup && !pwrite) begin
            unique case (paddr)
                CTRL_OFFSET:  rdata_r <= {24'h00_0000, ctrlView};
                MUX_OFFSET:   rdata_r <= {26'h000_0000, negSel_r,
                                          2'b00, posSel_r};
                MODE_OFFSET:  rdata_r <= {30'h0000_0000, respTime_r};
                RESET_OFFSET: rdata_r <= {31'h0000_0000, resetEn_r};
                default:      rdata_r <= '0;
            endcase
        end
    end

    // control register fields
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            enable_r <= CTRL_RESET[ENABLE_POS];
            posHys_r <= CTRL_RESET[POS_HYS_LSB +: 2];
            negHys_r <= CTRL_RESET[NEG_HYS_LSB +: 2];
        end else if (wrCtrl) begin
            enable_r <= pwdata[ENABLE_POS];
            posHys_r <= pwdata[POS_HYS_LSB +: 2];
            negHys_r <= pwdata[NEG_HYS_LSB +: 2];
        end
    end

    // a new edge beats a software clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            riseFlag_r <= CTRL_RESET[RISE_POS];
            fallFlag_r <= CTRL_RESET[FALL_POS];
        end else begin
            if (riseEdge) begin
                riseFlag_r <= 1'b1;
            end else if (wrCtrl && !pwdata[RISE_POS]) begin
                riseFlag_r <= 1'b0;
            end
            if (fallEdge) begin
                fallFlag_r <= 1'b1;
            end else if (wrCtrl && !pwdata[FALL_POS]) begin
                fallFlag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            posSel_r <= MUX_RESET[POS_SEL_LSB +: 2];
            negSel_r <= MUX_RESET[NEG_SEL_LSB - 2 +: 2];
        end else if (wrMux) begin
            posSel_r <= pwdata[POS_SEL_LSB +: 2];
            negSel_r <= pwdata[NEG_SEL_LSB +: 2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            respTime_r <= MODE_RESET;
        end else if (wrMode) begin
            respTime_r <= pwdata[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            resetEn_r <= RSTEN_RESET;
        end else if (wrRst) begin
            resetEn_r <= pwdata[0];
        end
    end

    // output path: history, latched pin, events and reset request
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prevOut_r  <= 1'b0;
            latched_r  <= 1'b0;
            riseEv_r   <= 1'b0;
            fallEv_r   <= 1'b0;
            resetReq_r <= 1'b0;
        end else begin
            prevOut_r  <= syncOut;
            latched_r  <= enable_r && syncOut;
            riseEv_r   <= riseEdge;
            fallEv_r   <= fallEdge;
            // low output means positive input below negative input
            resetReq_r <= resetEn_r && enable_r && !syncOut;
        end
    end

    assign prdata               = rdata_r;
    assign pready               = ready_r;
    assign pslverr              = err_r;
    assign cmpEnable            = enable_r;
    assign pos_input_select     = posSel_r;
    assign neg_input_select     = negSel_r;
    assign response_time_select = respTime_r;
    assign pos_hysteresis_sel   = posHys_r;
    assign neg_hysteresis_sel   = negHys_r;
    assign cmp_latched_out      = latched_r;
    assign risingEvent          = riseEv_r;
    assign fallingEvent         = fallEv_r;
    assign cmpResetReq          = resetReq_r;
    // raw path has no flop so it works with the clock stopped
    assign cmp_raw_out          = cmpRawIn && enable_r;
    // cmpRawIn is high when the positive input is the larger

endmodule : comparator_control_logic

`default_nettype wire

// File: tb/cmp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_core_model (
    // analog levels, arbitrary millivolt units
    input  wire logic [7:0] posLevel,
    input  wire logic [7:0] negLevel,
    // raw decision
    output logic            cmpRawIn
);
    // hysteresis is not modelled, so the bench keeps levels far apart
    assign cmpRawIn = posLevel > negLevel;
endmodule : cmp_core_model
`default_nettype wire

// File: tb/cmp_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_chk
    import cmp_ctrl_pkg::*;
(
    // clock, reset and apb
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // comparator core
    input wire logic        cmpRawIn,
    input wire logic        cmpEnable,
    input wire logic [1:0]  pos_input_select,
    input wire logic [1:0]  neg_input_select,
    input wire logic [1:0]  response_time_select,
    input wire logic [1:0]  pos_hysteresis_sel,
    input wire logic [1:0]  neg_hysteresis_sel,
    // pins and system
    input wire logic        cmp_latched_out,
    input wire logic        cmp_raw_out,
    input wire logic        risingEvent,
    input wire logic        fallingEvent,
    input wire logic        cmpResetReq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_raw_gate: assert property (
        cmp_raw_out == (cmpRawIn && cmpEnable))
        else $error("raw pin not gated by enable");
    chk_latch_off: assert property (
        !cmpEnable && !$past(cmpEnable) |-> !cmp_latched_out)
        else $error("latched pin high while disabled");
    chk_rise_latch: assert property (
        risingEvent |-> $rose(cmp_latched_out))
        else $error("rising event without latched rise");
    chk_fall_latch: assert property (
        fallingEvent && $past(cmpEnable, 2) |-> $fell(cmp_latched_out))
        else $error("falling event without latched fall");
    chk_event_enabled: assert property (
        risingEvent || fallingEvent |-> $past(cmpEnable))
        else $error("edge event while disabled");
    chk_reset_low: assert property (
        cmpResetReq |-> !cmp_latched_out)
        else $error("reset request with output high");
    chk_ready_next: assert property (
        psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_mux_hold: assert property (
        $changed(pos_input_select) || $changed(neg_input_select)
        |-> $past(pready) && $past(pwrite))
        else $error("input select moved without a write");
    chk_mode_hold: assert property (
        $changed(response_time_select) |-> $past(pready) && $past(pwrite))
        else $error("response time moved without a write");
    chk_hys_hold: assert property (
        $changed(pos_hysteresis_sel) |-> $past(pready) && $past(pwrite))
        else $error("hysteresis moved without a write");

    cov_rise: cover property (risingEvent);
    cov_fall: cover property (fallingEvent);
    cov_reset: cover property (cmpResetReq);
endmodule : cmp_ctrl_chk

bind comparator_control_logic cmp_ctrl_chk cmp_ctrl_chk_i (.*);
`default_nettype wire

// File: tb/comparator_control_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module comparator_control_logic_test
    import cmp_ctrl_pkg::*;
;
    logic        ref_clk, pready, pslverr, re, cmpRawIn, cmpEnable;
    logic        cmp_latched_out, cmp_raw_out, cmpResetReq;
    logic        risingEvent, fallingEvent;
    logic        sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [3:0]  pstrb = 4'hF;
    logic [1:0]  pos_input_select, neg_input_select, response_time_select;
    logic [1:0]  pos_hysteresis_sel, neg_hysteresis_sel;
    logic [7:0]  posLevel = 8'h10, negLevel = 8'h80;
    int          bad_count = 0, checked = 0;

    comparator_control_logic comparator_control_logic_i (.*);
    cmp_core_model cmp_core_model_i (.*);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // one edge passes first so back-to-back calls never drive psel twice
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) bad_count++;
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // a write lands on the sampling edge; let it settle before checks
        @(posedge ref_clk);
    endtask : apb

    task automatic t_fields();
        logic [1:0] c;
        apb(1'b0, CTRL_OFFSET, 32'h0); check(rv, 32'h0);
        apb(1'b1, MUX_OFFSET, 32'h31); check({pos_input_select, neg_input_select}, 4'h7);
        apb(1'b1, MODE_OFFSET, 32'h2); check(response_time_select, 2'h2);
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            apb(1'b1, CTRL_OFFSET, {28'h0, c, ~c});
            check({pos_hysteresis_sel, neg_hysteresis_sel}, {c, ~c});
            apb(1'b0, CTRL_OFFSET, 32'h0); check(rv, {28'h0, c, ~c});
        end
        $display("field test done");
    endtask : t_fields

    task automatic t_edges();
        apb(1'b1, CTRL_OFFSET, 32'h80);
        posLevel <= 8'hC0;
        repeat (6) @(posedge ref_clk);
        check({cmp_raw_out, cmp_latched_out}, 2'b11);
        apb(1'b0, CTRL_OFFSET, 32'h0); check(rv, 32'hE0);
        posLevel <= 8'h20;
        repeat (6) @(posedge ref_clk);
        apb(1'b0, CTRL_OFFSET, 32'h0); check(rv, 32'hB0);
        apb(1'b1, CTRL_OFFSET, 32'hB0);
        apb(1'b0, CTRL_OFFSET, 32'h0); check(rv, 32'hB0);
        apb(1'b1, CTRL_OFFSET, 32'h80);
        apb(1'b0, CTRL_OFFSET, 32'h0); check(rv, 32'h80);
        $display("edge test done");
    endtask : t_edges

    task automatic t_disable();
        posLevel <= 8'hC0;
        repeat (6) @(posedge ref_clk);
        apb(1'b1, CTRL_OFFSET, 32'h0);
        repeat (2) @(posedge ref_clk);
        check({cmp_raw_out, cmp_latched_out, cmpEnable}, 3'b000);
        posLevel <= 8'h20;
        repeat (6) @(posedge ref_clk);
        posLevel <= 8'hC0;
        repeat (6) @(posedge ref_clk);
        apb(1'b1, CTRL_OFFSET, 32'h80);
        repeat (6) @(posedge ref_clk);
        apb(1'b0, CTRL_OFFSET, 32'h0); check(rv[5:4], 2'b00);
        $display("disable test done");
    endtask : t_disable

    task automatic t_reset_src();
        apb(1'b1, RESET_OFFSET, 32'h1); check(cmpResetReq, 1'b0);
        posLevel <= 8'h20;
        repeat (6) @(posedge ref_clk);
        check(cmpResetReq, 1'b1);
        apb(1'b0, 12'h200, 32'h0);
        check(re, 1'b1);
        check(rv, 32'h0);
        $display("reset source test done");
    endtask : t_reset_src

    initial begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_fields();
        t_edges();
        t_disable();
        t_reset_src();
        finish_test();
    end
endmodule : comparator_control_logic_test
`default_nettype wire
